// File: src/flash_cmd_defs.svh
/* Command codes, word offsets, field positions and reset values of the command decoder.
   Assumes it is included by bare name from the package and the decoder. */
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH
`define ADDR_W          24
`define DATA_W          16
`define PART_HI         23
`define PART_LO         21
`define BLK_LO          17
`define BLOCKS          128
`define PARTS           8
`define CMD_CFG_SETUP   16'h0060
`define CMD_CFG_READ    16'h0003
`define CMD_CFG_ENH     16'h0004
`define CMD_LOCK        16'h0001
`define CMD_LOCK_DOWN   16'h002f
`define CMD_OTP_SETUP   16'h00c0
`define CMD_READ_ARRAY  16'h00ff
`define CMD_READ_STATUS 16'h0070
`define CMD_CLEAR       16'h0050
`define CMD_READ_INFO   16'h0090
`define CMD_QUERY       16'h0098
`define CMD_WORD_PROG   16'h0041
`define CMD_BUF_PROG    16'h00e9
`define CMD_BULK_PROG   16'h0080
`define CMD_ERASE       16'h0020
`define CMD_SUSPEND     16'h00b0
`define CMD_CONFIRM     16'h00d0
`define OTP_LOCK0_OFS   9'h080
`define OTP_REG0_OFS    9'h081
`define OTP_LOCK1_OFS   9'h089
`define OTP_REG1_OFS    9'h08a
`define OTP_LAST_OFS    9'h109
`define OTP_REG0_WORDS  9'h008
`define OTP_UID_WORDS   8'h04
`define OTP_WORDS       136
`define OTP_FILL        16'hffff
`define LOCK0_RESET     16'hfffe
`define LOCK1_RESET     16'hffff
`define INFO_MFR_OFS    9'h000
`define INFO_DEV_OFS    9'h001
`define INFO_LOCK_OFS   9'h002
`define INFO_RCFG_OFS   9'h005
`define INFO_ECFG_OFS   9'h006
`define RCFG_RESET      16'hffff
`define ECFG_RESET      16'h0000
`endif

// File: src/flash_cmd_pkg.sv
/* Types shared by the command decoder: sequencer states, read modes, operation requests.
   Assumes the definitions header is on the include path. */
`include "flash_cmd_defs.svh"
package flash_cmd_pkg;
	typedef enum logic [9:0] {
		S_IDLE     = 10'h001,
		S_CFG      = 10'h002,
		S_OTP      = 10'h004,
		S_WORD     = 10'h008,
		S_BUF_CNT  = 10'h010,
		S_BUF_DATA = 10'h020,
		S_BUF_CFM  = 10'h040,
		S_EFP_CFM  = 10'h080,
		S_EFP_DATA = 10'h100,
		S_ERASE    = 10'h200
	} cmd_state_t;
	typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_INFO, RM_QUERY} read_mode_t;
	typedef enum logic [2:0] {
		OP_PROG, OP_BUF_LOAD, OP_BUF_COMMIT, OP_EFP_START, OP_EFP_WORD, OP_EFP_EXIT, OP_ERASE
	} op_kind_t;
	typedef enum logic [1:0] {OTP_NONE, OTP_LOCK0, OTP_LOCK1, OTP_DATA} otp_kind_t;
	typedef struct packed {
		otp_kind_t  kind;
		logic [7:0] idx;
	} otp_loc_t;
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} bus_word_t;
	typedef struct packed {
		op_kind_t           kind;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} op_req_t;
endpackage : flash_cmd_pkg

// File: src/flash_cmd_decoder.sv
/* Command decoder: bus writes become read modes, operations, locks and security-word writes.
   Assumes bus strobes and the write machine run on clk_sys_in; the protect pin is asynchronous. */
// Operation
// R01 - Seventeen 128-bit security words, two lock words.
// R02 - Lock word 0 guards word 0; 1 the rest.
// R03 - Word 0: factory lower half, user upper half.
// R04 - Stored bits only ever go from one to zero; here rst_in reloads every security word and lock word to its initial value.
// R05 - Cleared lock bit blocks its word for good; here rst_in sets the lock words back to LOCK0_RESET and LOCK1_RESET.
// R06 - Locked word write sets program and lock errors.
// R07 - Host writes 00C0h, then data to target.
// R08 - Sixteen bits per write; zeros clear bits.
// R09 - Write outside security space sets program error.
// R10 - Host reads words in device-information mode.
// R11 - Config setup writes read or enhanced word.
// R12 - 00FFh puts partition in array read.
// R13 - 0070h puts partition in status read.
// R14 - 0050h clears every status error flag.
// R15 - 0090h information mode, 0098h query mode.
// R16 - 0041h: next write programs one word.
// R17 - Buffered program: 00E9h, words, then 00D0h.
// R18 - Bulk program: 0080h, 00D0h, then words.
// R19 - 0020h then 00D0h erases the block.
// R20 - 00B0h suspends; flags show which was suspended.
// R21 - 00D0h resumes; nested program resumes first.
// R22 - Lock setup: 0001h lock, 00D0h unlock, 002Fh down.
// R23 - Bad sequence sets program and erase errors.
// R24 - Top status bit is one when ready.
`include "flash_cmd_defs.svh"
module flash_cmd_decoder
	import flash_cmd_pkg::*;
#(
	parameter logic [63:0]        FACTORY_UID = 64'h0123_4567_89ab_cdef,
	parameter logic [`DATA_W-1:0] ID_MFR      = 16'h005a,
	parameter logic [`DATA_W-1:0] ID_DEV      = 16'h00a5
) (
	input  wire logic               clk_sys_in,
	input  wire logic               rst_in,
	input  wire logic               bus_we_in,
	input  wire logic               bus_re_in,
	input  wire bus_word_t          bus_in,
	input  wire logic [`DATA_W-1:0] array_data_in,
	input  wire logic               wp_n_in,
	input  wire logic               wsm_done_in,
	input  wire logic               wsm_fail_in,
	output logic [`DATA_W-1:0]      read_data_out,
	output logic                    op_valid_out,
	output op_req_t                 op_out,
	output logic                    wsm_run_out,
	output logic [`DATA_W-1:0]      read_config_out,
	output logic [`DATA_W-1:0]      enhanced_config_out
);
	/* ID_MFR, ID_DEV and FACTORY_UID values are arbitrary. */
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	function automatic otp_loc_t otp_map(input logic [8:0] off);
		otp_loc_t r;
		r.kind = OTP_NONE;
		r.idx  = 8'h00;
		if (off == `OTP_LOCK0_OFS) begin
			r.kind = OTP_LOCK0;
		end else if (off == `OTP_LOCK1_OFS) begin
			r.kind = OTP_LOCK1;
		end else if (off > `OTP_LOCK0_OFS && off < `OTP_LOCK1_OFS) begin
			r.kind = OTP_DATA;
			r.idx  = 8'(off - `OTP_REG0_OFS);
		end else if (off > `OTP_LOCK1_OFS && off <= `OTP_LAST_OFS) begin
			r.kind = OTP_DATA;
			r.idx  = 8'(off - `OTP_REG1_OFS + `OTP_REG0_WORDS);
		end
		return r;
	endfunction : otp_map

	function automatic logic otp_locked(input logic [7:0] idx, input logic [15:0] l0, input logic [15:0] l1);
		logic [7:0] rel;
		rel = idx - 8'h08;
		if (idx < `OTP_UID_WORDS) return ~l0[0];
		else if (idx < 8'h08) return ~l0[1];
		else return ~l1[rel[6:3]];
	endfunction : otp_locked

	cmd_state_t         state;
	cmd_state_t         next_state;
	cmd_state_t         idle_next;
	read_mode_t         mode [`PARTS];
	logic [15:0]        otp_mem [`OTP_WORDS];
	logic [15:0]        lock0;
	logic [15:0]        lock1;
	logic [`BLOCKS-1:0] blk_lock;
	logic [`BLOCKS-1:0] blk_down;
	logic               op_prog;
	logic               op_erase;
	logic               psusp;
	logic               esusp;
	logic               perr;
	logic               eerr;
	logic               lerr;
	logic [8:0]         buf_cnt;
	logic [6:0]         buf_blk;
	logic               wp_s1;
	logic               wp_s2;
	logic               wp_s3;
	logic               wp_level;

	wire [15:0] d      = bus_in.data;
	wire [2:0]  part   = bus_in.addr[`PART_HI:`PART_LO];
	wire [6:0]  blk    = bus_in.addr[`PART_HI:`BLK_LO];
	wire        idle   = state == S_IDLE;
	wire        w_idle = bus_we_in & idle;
	wire        busy   = (op_prog & ~psusp) | (op_erase & ~esusp & ~op_prog);
	wire        free   = ~busy & ~psusp;
	wire        quiet  = free & ~esusp;
	wire        lk     = blk_lock[blk];
	wire        same   = blk == buf_blk;
	wire        wp_low = ~wp_level;
	wire        is_ff  = d == `CMD_READ_ARRAY;
	wire        is_70  = d == `CMD_READ_STATUS;
	wire        is_50  = d == `CMD_CLEAR;
	wire        is_90  = d == `CMD_READ_INFO;
	wire        is_98  = d == `CMD_QUERY;
	wire        is_b0  = d == `CMD_SUSPEND;
	wire        is_d0  = d == `CMD_CONFIRM;
	wire        k60    = d == `CMD_CFG_SETUP & free;
	wire        kc0    = d == `CMD_OTP_SETUP & quiet;
	wire        k41    = d == `CMD_WORD_PROG & free;
	wire        ke9    = d == `CMD_BUF_PROG & free;
	wire        k80    = d == `CMD_BULK_PROG & quiet;
	wire        k20    = d == `CMD_ERASE & quiet;
	wire        known  = is_ff | is_70 | is_50 | is_90 | is_98 | is_b0 | is_d0;
	wire        clr    = w_idle & is_50;
	wire        sus    = w_idle & is_b0 & busy;
	wire        res    = w_idle & is_d0 & (psusp | (esusp & ~op_prog));
	wire        done   = wsm_done_in & busy;

	wire        cfg_go   = bus_we_in & state == S_CFG;
	wire        c_rcfg   = cfg_go & d == `CMD_CFG_READ;
	wire        c_ecfg   = cfg_go & d == `CMD_CFG_ENH;
	wire        c_lock   = cfg_go & d == `CMD_LOCK;
	wire        c_unlock = cfg_go & is_d0 & ~(blk_down[blk] & wp_low);
	wire        c_down   = cfg_go & d == `CMD_LOCK_DOWN;
	wire        cfg_bad  = cfg_go & ~(c_rcfg | c_ecfg | c_lock | is_d0 | c_down);

	wire        otp_go    = bus_we_in & state == S_OTP;
	otp_loc_t   wr_loc;
	assign wr_loc = otp_map(bus_in.addr[8:0]);
	wire        otp_space = otp_go & wr_loc.kind == OTP_NONE; // R09
	wire        otp_lockf = otp_go & wr_loc.kind == OTP_DATA & otp_locked(wr_loc.idx, lock0, lock1);
	wire        otp_ok    = otp_go & ~otp_space & ~otp_lockf;

	wire        word_go   = bus_we_in & state == S_WORD;
	wire        buf_load  = bus_we_in & state == S_BUF_DATA & same;
	wire        buf_abort = bus_we_in & state == S_BUF_DATA & ~same;
	wire        commit    = bus_we_in & state == S_BUF_CFM & is_d0 & same;
	wire        efp_cfm   = bus_we_in & state == S_EFP_CFM & is_d0;
	wire        efp_word  = bus_we_in & state == S_EFP_DATA & same;
	wire        efp_exit  = bus_we_in & state == S_EFP_DATA & ~same;
	wire        erase_cfm = bus_we_in & state == S_ERASE & is_d0;
	wire        prog_lkf  = (word_go | commit | efp_cfm) & lk;
	wire        erase_lkf = erase_cfm & lk;
	wire        word_ok   = word_go & ~lk;
	wire        commit_ok = commit & ~lk;
	wire        efp_ok    = efp_cfm & ~lk;
	wire        erase_ok  = erase_cfm & ~lk;
	wire        prog_go   = word_ok | commit_ok | efp_ok;
	wire        op_fire   = prog_go | buf_load | efp_word | efp_exit | erase_ok;

	wire        idle_bad  = w_idle & ~(k60 | kc0 | k41 | ke9 | k80 | k20 | known);
	wire        seq_err   = idle_bad | cfg_bad | buf_abort
		| (bus_we_in & state == S_BUF_CFM & ~commit)
		| (bus_we_in & (state == S_EFP_CFM | state == S_ERASE) & ~is_d0);
	wire        set_perr  = seq_err | otp_space | otp_lockf | prog_lkf | (done & wsm_fail_in & op_prog);
	wire        set_eerr  = seq_err | erase_lkf | (done & wsm_fail_in & ~op_prog);
	wire        set_lerr  = otp_lockf | prog_lkf | erase_lkf;

	op_kind_t   kind;
	assign kind = word_ok ? OP_PROG : buf_load ? OP_BUF_LOAD : commit_ok ? OP_BUF_COMMIT :
		efp_ok ? OP_EFP_START : efp_word ? OP_EFP_WORD : efp_exit ? OP_EFP_EXIT : OP_ERASE;

	wire        mode_wr = (w_idle & (is_ff | is_70 | is_90 | is_98 | k60)) | word_go | commit | efp_cfm | erase_cfm;
	read_mode_t mode_val;
	assign mode_val = (w_idle & is_ff) ? RM_ARRAY : (w_idle & is_90) ? RM_INFO :
		(w_idle & is_98) ? RM_QUERY : RM_STATUS;

	assign idle_next = k60 ? S_CFG : kc0 ? S_OTP : k41 ? S_WORD : ke9 ? S_BUF_CNT :
		k80 ? S_EFP_CFM : k20 ? S_ERASE : S_IDLE;

	always_comb begin
		next_state = state;
		if (bus_we_in) begin
			case (state)
				S_IDLE:     next_state = idle_next;
				S_BUF_CNT:  next_state = S_BUF_DATA;
				S_BUF_DATA: next_state = ~same ? S_IDLE : (buf_cnt == 9'h000) ? S_BUF_CFM : S_BUF_DATA;
				S_EFP_CFM:  next_state = efp_ok ? S_EFP_DATA : S_IDLE;
				S_EFP_DATA: next_state = same ? S_EFP_DATA : S_IDLE;
				default:    next_state = S_IDLE;
			endcase
		end
	end

	otp_loc_t    rd_loc;
	assign rd_loc = otp_map(bus_in.addr[8:0]);
	wire [15:0]  status_word = {8'h00, ~busy, esusp, eerr, perr, 1'b0, psusp, lerr, 1'b0};
	wire [15:0]  info_word =
		rd_loc.kind == OTP_LOCK0 ? lock0 :
		rd_loc.kind == OTP_LOCK1 ? lock1 :
		rd_loc.kind == OTP_DATA ? otp_mem[rd_loc.idx] :
		bus_in.addr[8:0] == `INFO_MFR_OFS ? ID_MFR :
		bus_in.addr[8:0] == `INFO_DEV_OFS ? ID_DEV :
		bus_in.addr[8:0] == `INFO_LOCK_OFS ? {14'h0000, blk_down[blk], blk_lock[blk]} :
		bus_in.addr[8:0] == `INFO_RCFG_OFS ? read_config_out :
		bus_in.addr[8:0] == `INFO_ECFG_OFS ? enhanced_config_out : 16'h0000;
	wire [15:0]  rd_word = mode[part] == RM_ARRAY ? array_data_in : mode[part] == RM_STATUS ? status_word :
		mode[part] == RM_INFO ? info_word : 16'h0000;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state    <= S_IDLE;
			op_prog  <= 1'b0;
			op_erase <= 1'b0;
			psusp    <= 1'b0;
			esusp    <= 1'b0;
			perr     <= 1'b0;
			eerr     <= 1'b0;
			lerr     <= 1'b0;
		end else begin
			state <= next_state;
			if (prog_go) op_prog <= 1'b1; // R16 R17 R18
			else if (done & op_prog) op_prog <= 1'b0;
			if (erase_ok) op_erase <= 1'b1; // R19
			else if (done & ~op_prog) op_erase <= 1'b0;
			if (sus & op_prog) psusp <= 1'b1; // R20
			else if (res & psusp) psusp <= 1'b0; // R21
			if (sus & ~op_prog) esusp <= 1'b1; // R20
			else if (res & ~psusp) esusp <= 1'b0; // R21
			perr <= (perr & ~clr) | set_perr; // R14 R23
			eerr <= (eerr & ~clr) | set_eerr; // R14 R23
			lerr <= (lerr & ~clr) | set_lerr; // R06
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			buf_cnt  <= 9'h000;
			buf_blk  <= 7'h00;
			blk_lock <= '1;
			blk_down <= '0;
			wp_s1    <= 1'b0;
			wp_s2    <= 1'b0;
			wp_s3    <= 1'b0;
			wp_level <= 1'b0;
		end else begin
			wp_s1 <= wp_n_in;
			wp_s2 <= wp_s1;
			wp_s3 <= wp_s2;
			if (wp_s2 == wp_s3) wp_level <= wp_s3;
			if (w_idle) buf_blk <= blk;
			if (bus_we_in & state == S_BUF_CNT) buf_cnt <= d[8:0];
			else if (buf_load) buf_cnt <= buf_cnt - 9'h001;
			if (c_lock) blk_lock[blk] <= 1'b1; // R22
			if (c_unlock) blk_lock[blk] <= 1'b0; // R22
			if (c_down) blk_down[blk] <= 1'b1; // R22
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < `PARTS; i++) mode[i] <= RM_ARRAY;
			read_config_out     <= `RCFG_RESET;
			enhanced_config_out <= `ECFG_RESET;
			read_data_out       <= 16'h0000;
			op_valid_out        <= 1'b0;
			op_out              <= '0;
			wsm_run_out         <= 1'b0;
		end else begin
			if (mode_wr) mode[part] <= mode_val; // R12 R13 R15
			if (c_rcfg) read_config_out <= bus_in.addr[15:0]; // R11
			if (c_ecfg) enhanced_config_out <= bus_in.addr[15:0]; // R11
			if (bus_re_in) read_data_out <= rd_word; // R10 R24
			op_valid_out <= op_fire;
			op_out       <= '{kind: kind, addr: bus_in.addr, data: d};
			wsm_run_out  <= busy;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lock0 <= `LOCK0_RESET; // R02
			lock1 <= `LOCK1_RESET;
			for (int i = 0; i < `OTP_WORDS; i++) // R01 R03
				otp_mem[i] <= (i < 4) ? FACTORY_UID[16*(i%4) +: 16] : `OTP_FILL;
		end else if (otp_ok) begin
			case (wr_loc.kind)
				OTP_LOCK0: lock0 <= lock0 & d; // R04 R08
				OTP_LOCK1: lock1 <= lock1 & d; // R04 R08
				OTP_DATA:  otp_mem[wr_loc.idx] <= otp_mem[wr_loc.idx] & d; // R05 R08
				default:   lock0 <= lock0;
			endcase
		end
	end

	sequence word_pair;
		w_idle & k41 ##[1:8] bus_we_in & state == S_WORD & ~lk;
	endsequence
	sequence erase_pair;
		w_idle & k20 ##[1:8] bus_we_in & state == S_ERASE & is_d0 & ~lk;
	endsequence

	ready_bit_a : assert property (bus_re_in & mode[part] == RM_STATUS |=> read_data_out[7] == $past(~busy)) // R24
		else $error("Ready bit does not track the machine.");
	seq_error_a : assert property (idle_bad |=> perr && eerr) // R23
		else $error("Bad sequence did not flag both errors.");
	clear_errs_a : assert property (clr & ~wsm_done_in |=> !perr && !eerr && !lerr) // R14
		else $error("Clear left an error flag set.");
	otp_lock_a : assert property (otp_lockf |=> // R06
		perr && lerr && otp_mem[$past(wr_loc.idx)] == $past(otp_mem[wr_loc.idx]))
		else $error("Locked word write not refused.");
	otp_space_a : assert property (otp_space |=> perr) // R09
		else $error("Out of space write did not flag.");
	otp_oneway_a : assert property (otp_ok & wr_loc.kind == OTP_DATA |=> // R04
		(otp_mem[$past(wr_loc.idx)] & ~$past(otp_mem[wr_loc.idx])) == 16'h0000)
		else $error("A security bit went from zero to one.");
	word_prog_a : assert property (word_pair |=> op_valid_out && op_out.kind == OP_PROG && !wsm_run_out ##1 wsm_run_out) // R16
		else $error("Word program not started.");
	erase_go_a : assert property (erase_pair |=> op_valid_out && op_out.kind == OP_ERASE && op_erase) // R19
		else $error("Erase not started.");
	nest_resume_a : assert property (res & psusp & esusp |=> !psusp && esusp) // R21
		else $error("Nested resume did not favour program.");
endmodule : flash_cmd_decoder

// File: bench/flash_wsm_model.sv
/* Write machine and array model for the command decoder bench: records requests and ends runs.
   Assumes the decoder clock and reset, and a run latency chosen by the bench. */
module flash_wsm_model
	import flash_cmd_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       op_valid_in,
	input  wire op_req_t    op_in,
	input  wire logic       run_in,
	input  wire logic [7:0] lat_in,
	input  wire bus_word_t  bus_in,
	output logic            done_out,
	output logic            fail_out,
	output logic [15:0]     array_out
);
	timeunit 1ns;
	timeprecision 1ns;
	op_req_t    last_op;
	int         n_done;
	int         pend;
	logic [7:0] cnt;
	wire        starts = op_valid_in && (op_in.kind inside {OP_PROG, OP_BUF_COMMIT, OP_ERASE, OP_EFP_EXIT});
	wire        counting = run_in && (pend != 0);
	// Array data follows the address, so a stale read word cannot pass for a fresh one.
	assign array_out = bus_in.addr[15:0] ^ 16'ha5a5;
	assign fail_out  = 1'b0;
	// Runs only advance while the decoder lets the machine run; a suspend clears the count, so the run restarts after resume.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_op  <= '0;
			n_done   <= 0;
			pend     <= 0;
			cnt      <= 8'h00;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (op_valid_in) begin
				last_op <= op_in;
			end
			if (counting && (cnt + 8'h01 >= lat_in)) begin
				done_out <= 1'b1;
				cnt      <= 8'h00;
				n_done   <= n_done + 1;
				pend     <= pend - 1 + int'(starts);
			end else begin
				cnt  <= counting ? cnt + 8'h01 : 8'h00;
				pend <= pend + int'(starts);
			end
		end
	end
endmodule : flash_wsm_model

// File: bench/test_flash_command_decoder_otp.sv
/* Self-checking bench for the command decoder: a table of writes, reads and waits, then resets.
   Assumes the package and the write machine model are compiled before it. */
module test_flash_command_decoder_otp
	import flash_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		byte         k;
		logic [23:0] a;
		logic [15:0] d;
	} step_t;
	localparam int          N_STEPS = 142;
	localparam logic [63:0] UID     = 64'h1357_9bdf_2468_ace0;
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        bus_we_in = 1'b0;
	logic        bus_re_in = 1'b0;
	logic        wp_n_in = 1'b0;
	bus_word_t   bus_in = '0;
	logic [7:0]  lat = 8'h03;
	logic        wsm_done_in, wsm_fail_in, op_valid_out, wsm_run_out;
	op_req_t     op_out;
	logic [15:0] array_data_in, read_data_out, read_config_out, enhanced_config_out;
	int          err_count = 0;
	int          check_count = 0;
	int          seen_done = 0;
	// Kinds: W write, R read and compare, digit compares the last request kind, D waits for a run end.
	// L sets the run latency and P sets the protect pin; an address of all ones skips address and data.
	step_t steps [N_STEPS] = '{
		'{"W",24'h0,16'h70}, '{"R",24'h0,16'h80},
		'{"W",24'h0,16'h90}, '{"R",24'h0,16'hc3}, '{"R",24'h1,16'h3c},
		'{"R",24'h80,16'hfffe}, '{"R",24'h81,16'hace0}, '{"R",24'h84,16'h1357},
		'{"R",24'h85,16'hffff}, '{"R",24'h89,16'hffff}, '{"R",24'h20002,16'h1},
		'{"W",24'h0,16'h98}, '{"R",24'h0,16'h0}, '{"W",24'h0,16'hff}, '{"R",24'h123,16'ha486},
		'{"W",24'h0,16'h60}, '{"W",24'h1234,16'h3}, '{"W",24'h0,16'h60}, '{"W",24'h5678,16'h4},
		'{"W",24'h0,16'h90}, '{"R",24'h5,16'h1234}, '{"R",24'h6,16'h5678},
		'{"W",24'h0,16'hc0}, '{"W",24'h85,16'hff00}, '{"W",24'h0,16'h90}, '{"R",24'h85,16'hff00},
		'{"W",24'h0,16'hc0}, '{"W",24'h85,16'h0ff0}, '{"W",24'h0,16'h90}, '{"R",24'h85,16'h0f00},
		'{"W",24'h0,16'hc0}, '{"W",24'h81,16'h0}, '{"W",24'h0,16'h70}, '{"R",24'h0,16'h92},
		'{"W",24'h0,16'h50}, '{"R",24'h0,16'h80}, '{"W",24'h0,16'h90}, '{"R",24'h81,16'hace0},
		'{"W",24'h0,16'hc0}, '{"W",24'h110,16'h0}, '{"W",24'h0,16'h70}, '{"R",24'h0,16'h90},
		'{"W",24'h0,16'h50}, '{"W",24'h0,16'hc0}, '{"W",24'h89,16'hfffe}, '{"W",24'h0,16'hc0},
		'{"W",24'h8a,16'h0}, '{"W",24'h0,16'h70}, '{"R",24'h0,16'h92}, '{"W",24'h0,16'h50},
		'{"W",24'h0,16'hc0}, '{"W",24'h92,16'h1234}, '{"W",24'h0,16'h90}, '{"R",24'h8a,16'hffff},
		'{"R",24'h92,16'h1234}, '{"R",24'h89,16'hfffe},
		'{"W",24'h0,16'hc0}, '{"W",24'h80,16'hfffc}, '{"W",24'h0,16'hc0}, '{"W",24'h86,16'h0},
		'{"W",24'h0,16'h70}, '{"R",24'h0,16'h92}, '{"W",24'h0,16'h50},
		'{"W",24'h0,16'h60}, '{"W",24'h0,16'haa}, '{"R",24'h0,16'hb0}, '{"W",24'h0,16'h50},
		'{"W",24'h0,16'h12}, '{"R",24'h0,16'hb0}, '{"W",24'h0,16'h50},
		'{"W",24'h20000,16'h60}, '{"W",24'h20000,16'hd0}, '{"W",24'h0,16'h90}, '{"R",24'h20002,16'h0},
		'{"W",24'h20000,16'h60}, '{"W",24'h20000,16'h1}, '{"W",24'h0,16'h90}, '{"R",24'h20002,16'h1},
		'{"W",24'h20000,16'h60}, '{"W",24'h20000,16'h2f}, '{"W",24'h0,16'h90}, '{"R",24'h20002,16'h3},
		'{"W",24'h20000,16'h60}, '{"W",24'h20000,16'hd0}, '{"W",24'h0,16'h90}, '{"R",24'h20002,16'h3},
		'{"P",24'h0,16'h1}, '{"W",24'h20000,16'h60}, '{"W",24'h20000,16'hd0}, '{"W",24'h0,16'h90},
		'{"R",24'h20002,16'h2}, '{"W",24'h40000,16'h60}, '{"W",24'h40000,16'hd0},
		'{"L",24'h0,16'h14}, '{"W",24'h20000,16'h41}, '{"W",24'h20010,16'hbeef}, '{"0",24'h20010,16'hbeef},
		'{"R",24'h0,16'h0}, '{"D",24'h0,16'h0}, '{"R",24'h0,16'h80},
		'{"L",24'h0,16'h3c}, '{"W",24'h20000,16'h20}, '{"W",24'h20000,16'hd0}, '{"6",24'hffffff,16'h0},
		'{"W",24'h0,16'hb0}, '{"R",24'h0,16'hc0},
		'{"W",24'h40000,16'h41}, '{"W",24'h40000,16'h1111}, '{"0",24'h40000,16'h1111},
		'{"W",24'h0,16'hb0}, '{"R",24'h0,16'hc4},
		'{"W",24'h0,16'hd0}, '{"R",24'h0,16'h40}, '{"D",24'h0,16'h0}, '{"R",24'h0,16'hc0},
		'{"W",24'h0,16'hd0}, '{"R",24'h0,16'h0}, '{"D",24'h0,16'h0}, '{"R",24'h0,16'h80},
		'{"L",24'h0,16'h3}, '{"W",24'h20000,16'he9}, '{"W",24'h20000,16'h1}, '{"W",24'h20000,16'haaaa},
		'{"W",24'h20001,16'hbbbb}, '{"W",24'h20000,16'hd0}, '{"2",24'hffffff,16'h0},
		'{"D",24'h0,16'h0}, '{"R",24'h0,16'h80},
		'{"W",24'h20000,16'he9}, '{"W",24'h20000,16'h1}, '{"W",24'h40000,16'hcccc}, '{"R",24'h0,16'hb0},
		'{"W",24'h0,16'h50},
		'{"W",24'h20000,16'h80}, '{"W",24'h20000,16'hd0}, '{"3",24'hffffff,16'h0},
		'{"W",24'h20005,16'h1234}, '{"4",24'hffffff,16'h0}, '{"W",24'h40000,16'hffff},
		'{"5",24'hffffff,16'h0}, '{"D",24'h0,16'h0}, '{"R",24'h0,16'h80}
	};
	always #50 clk_sys_in = ~clk_sys_in;
	// Identity values and the factory half are arbitrary.
	flash_cmd_decoder #(.FACTORY_UID(UID), .ID_MFR(16'h00c3), .ID_DEV(16'h003c)) i_flash_cmd_decoder (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_we_in(bus_we_in), .bus_re_in(bus_re_in),
		.bus_in(bus_in), .array_data_in(array_data_in), .wp_n_in(wp_n_in), .wsm_done_in(wsm_done_in),
		.wsm_fail_in(wsm_fail_in), .read_data_out(read_data_out), .op_valid_out(op_valid_out),
		.op_out(op_out), .wsm_run_out(wsm_run_out), .read_config_out(read_config_out),
		.enhanced_config_out(enhanced_config_out));
	flash_wsm_model i_flash_wsm_model (
		.clk_in(clk_sys_in), .rst_in(rst_in), .op_valid_in(op_valid_out), .op_in(op_out),
		.run_in(wsm_run_out), .lat_in(lat), .bus_in(bus_in), .done_out(wsm_done_in),
		.fail_out(wsm_fail_in), .array_out(array_data_in));
	task automatic check(input string name, input logic [42:0] exp, input logic [42:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic stop_test();
		$display("errors %0d in %0d checks", err_count, check_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		bus_we_in <= 1'b1;
		bus_in    <= '{addr: a, data: d};
		@(posedge clk_sys_in);
		bus_we_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [23:0] a, input logic [15:0] e);
		@(posedge clk_sys_in);
		bus_re_in <= 1'b1;
		bus_in    <= '{addr: a, data: 16'h0000};
		@(posedge clk_sys_in);
		bus_re_in <= 1'b0;
		@(negedge clk_sys_in);
		check("read_data_out", 43'(e), 43'(read_data_out));
	endtask : rd
	task automatic wait_done();
		for (int i = 0; i < 2000 && i_flash_wsm_model.n_done == seen_done; i++) begin
			@(posedge clk_sys_in);
		end
		if (i_flash_wsm_model.n_done == seen_done) begin
			err_count++;
			$display("mismatch wsm_done_in expected pulse seen none");
			stop_test();
		end else begin
			seen_done = i_flash_wsm_model.n_done;
		end
	endtask : wait_done
	task automatic chk_reset();
		check("read_config_out", 43'(16'hffff), 43'(read_config_out));
		check("enhanced_config_out", 43'(16'h0000), 43'(enhanced_config_out));
		check("wsm_run_out", 43'(1'b0), 43'(wsm_run_out));
		check("op_valid_out", 43'(1'b0), 43'(op_valid_out));
	endtask : chk_reset
	task automatic run_step(input step_t s);
		case (s.k)
			"W": wr(s.a, s.d);
			"R": rd(s.a, s.d);
			"D": wait_done();
			"L": lat <= s.d[7:0];
			"P": begin
				wp_n_in <= s.d[0];
				repeat (5) @(posedge clk_sys_in);
			end
			default: begin
				repeat (2) @(posedge clk_sys_in);
				@(negedge clk_sys_in);
				check("op_out.kind", 43'(s.k - "0"), 43'(i_flash_wsm_model.last_op.kind));
				if (s.a != 24'hffffff) begin
					check("op_out.addr", 43'(s.a), 43'(i_flash_wsm_model.last_op.addr));
					check("op_out.data", 43'(s.d), 43'(i_flash_wsm_model.last_op.data));
				end
			end
		endcase
	endtask : run_step
	initial begin
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		chk_reset();
		foreach (steps[i]) begin
			run_step(steps[i]);
		end
		check("read_config_out", 43'(16'h1234), 43'(read_config_out));
		check("enhanced_config_out", 43'(16'h5678), 43'(enhanced_config_out));
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk_reset();
		rst_in <= 1'b0;
		wr(24'h0, 16'h0090);
		rd(24'h80, 16'hfffe);
		stop_test();
	end
endmodule : test_flash_command_decoder_otp
